// ==== rtl/slot_arbiter.sv ====
// How it works
// (RULE1) One stolen word time per transfer, one word
// (RULE2) Repeating group of five numbered slots
// (RULE3) Owner gets its slot, nobody interferes
// (RULE4) At most five modules may be attached
// (RULE5) Single slot caps module at fifth of throughput
// (RULE6) Faster module owns more slots; selector 1,3
// (RULE7) Ownership fixed per slot or plug selected
// (RULE8) Module resolves its own internal sub-priorities
// (RULE9) Every slot usable, each has one owner
// (RULE10) Counter wraps one to five; grant on match
// (RULE11) Idle owner slot returns to program
`timescale 1ns/1ps
`default_nettype none
module slot_arbiter #(
	parameter logic [slot_arb_pkg::NUM_SLOTS-1:0] FIXED_MASK =
		slot_arb_pkg::FIXED_SLOT_MASK,
	parameter logic [slot_arb_pkg::NUM_SLOTS*slot_arb_pkg::PORT_W-1:0]
		FIXED_OWNER = slot_arb_pkg::FIXED_SLOT_OWNER
) (
	// Clock and reset
	input  wire logic                                    CLK_IN,
	input  wire logic                                    RST_N_IN,
	// Plug wiring for selectable slots
	input  wire logic [slot_arb_pkg::NUM_SLOTS-1:0]      SLOT_PLUG_EN_IN,
	input  wire logic [slot_arb_pkg::NUM_SLOTS*slot_arb_pkg::PORT_W-1:0]
	                                                     SLOT_PLUG_OWNER_IN,
	// Memory side
	output logic                                         STEAL_OUT,
	output logic                                         MEM_WE_OUT,
	output logic [slot_arb_pkg::ADDR_W-1:0]              MEM_ADDR_OUT,
	output logic [slot_arb_pkg::WORD_W-1:0]              MEM_WDATA_OUT,
	input  wire logic [slot_arb_pkg::WORD_W-1:0]         MEM_RDATA_IN,
	// Option modules
	slot_cycle_if.processor                              link
);
	localparam int NS = slot_arb_pkg::NUM_SLOTS;
	localparam int PW = slot_arb_pkg::PORT_W;
	localparam int AW = slot_arb_pkg::ADDR_W;
	localparam int WW = slot_arb_pkg::WORD_W;

	// Plug wiring is a pin level: two flops before use
	logic [NS-1:0]    plug_en_meta;
	logic [NS-1:0]    plug_en;
	logic [NS*PW-1:0] plug_owner_meta;
	logic [NS*PW-1:0] plug_owner;

	logic [slot_arb_pkg::SLOT_W-1:0] slot;
	logic [slot_arb_pkg::SLOT_W-1:0] next_slot;
	logic [PW-1:0]                   steal_port;
	logic                            steal_read;

	// Owner lookup for a one-based slot number
	function automatic logic [PW-1:0] owner_of(
		input logic [slot_arb_pkg::SLOT_W-1:0] s,
		input logic [NS*PW-1:0]                tbl
	);
		logic [slot_arb_pkg::SLOT_W-1:0] idx;
		idx = s - slot_arb_pkg::SLOT_FIRST;
		owner_of = tbl[idx*PW +: PW];
	endfunction

	function automatic logic slot_bit(
		input logic [slot_arb_pkg::SLOT_W-1:0] s,
		input logic [NS-1:0]                   m
	);
		logic [slot_arb_pkg::SLOT_W-1:0] idx;
		idx = s - slot_arb_pkg::SLOT_FIRST;
		slot_bit = m[idx];
	endfunction

	// Fixed slots take precedence over plug wiring, so one owner per slot
	wire             slot_fixed = slot_bit(slot, FIXED_MASK); // RULE7
	wire             slot_plug  = slot_bit(slot, plug_en);
	wire  [PW-1:0]   slot_owner = slot_fixed ?
		owner_of(slot, FIXED_OWNER) :
		owner_of(slot, plug_owner); // RULE9
	wire             slot_owned = slot_fixed | slot_plug;
	wire             owner_ok   = slot_owner < PW'(slot_arb_pkg::NUM_PORTS);
	// Only the owner may take the slot; idle owner leaves it to program
	wire             take       = slot_owned & owner_ok &
		link.req[slot_owner]; // RULE3 RULE11

	assign next_slot = (slot == slot_arb_pkg::SLOT_LAST) ?
		slot_arb_pkg::SLOT_FIRST :
		slot + slot_arb_pkg::SLOT_FIRST; // RULE2 RULE10

	// Grant is a one-hot decode of the owner, combinational handshake
	genvar g;
	generate
		for (g = 0; g < slot_arb_pkg::NUM_PORTS; g++) begin : gen_grant
			assign link.grant[g] = take &&
				(slot_owner == PW'(g)); // RULE10 RULE6
		end
	endgenerate
	assign link.slot = slot;

	always_ff @(posedge CLK_IN) begin
		plug_en_meta    <= SLOT_PLUG_EN_IN;
		plug_en         <= plug_en_meta;
		plug_owner_meta <= SLOT_PLUG_OWNER_IN;
		plug_owner      <= plug_owner_meta;
	end

	always_ff @(posedge CLK_IN) begin
		if (!RST_N_IN) begin
			slot <= slot_arb_pkg::SLOT_FIRST;
		end else begin
			slot <= next_slot; // RULE10
		end
	end

	// The stolen word time follows the granting word time
	always_ff @(posedge CLK_IN) begin
		if (!RST_N_IN) begin
			STEAL_OUT     <= 1'b0;
			MEM_WE_OUT    <= 1'b0;
			MEM_ADDR_OUT  <= '0;
			MEM_WDATA_OUT <= '0;
			steal_port    <= '0;
			steal_read    <= 1'b0;
		end else begin
			STEAL_OUT  <= take; // RULE1
			MEM_WE_OUT <= take & link.write[slot_owner]; // RULE1
			steal_read <= take & ~link.write[slot_owner];
			if (take) begin
				MEM_ADDR_OUT  <= link.addr[slot_owner*AW +: AW];
				MEM_WDATA_OUT <= link.wdata[slot_owner*WW +: WW];
				steal_port    <= slot_owner;
			end
		end
	end

	// Read word captured at the end of the stolen word time
	always_ff @(posedge CLK_IN) begin
		if (!RST_N_IN) begin
			link.rd_valid <= 1'b0;
			link.rd_port  <= '0;
			link.rdata    <= '0;
		end else begin
			link.rd_valid <= steal_read; // RULE1
			if (steal_read) begin
				link.rd_port <= steal_port;
				link.rdata   <= MEM_RDATA_IN;
			end
		end
	end
endmodule // slot_arbiter
`default_nettype wire

// ==== rtl/slot_arb_pkg.sv ====
package slot_arb_pkg;
	// Cycle group geometry
	localparam int NUM_SLOTS = 5;
	localparam int SLOT_W    = 3;
	localparam int PORT_W    = 3;
	localparam int NUM_PORTS = 5;
	localparam int WORD_W    = 18;
	localparam int ADDR_W    = 15;

	// Slot numbering, one-based
	localparam logic [SLOT_W-1:0] SLOT_FIRST = 3'h1;
	localparam logic [SLOT_W-1:0] SLOT_LAST  = 3'h5;

	// Throughput figures in words per second
	localparam int TOTAL_WORDS_PER_S = 144000;
	localparam int SLOT_WORDS_PER_S  = TOTAL_WORDS_PER_S / NUM_SLOTS;
	localparam int CS_WORDS_PER_S    = 57600;

	// Port numbering on the interface
	localparam logic [PORT_W-1:0] PORT_CONTROLLER_SELECTOR = 3'h0;
	localparam logic [PORT_W-1:0] PORT_PROCESSOR_LINK_UNIT = 3'h1;
	localparam logic [PORT_W-1:0] PORT_COMMON_PERIPHERAL   = 3'h2;
	localparam logic [PORT_W-1:0] PORT_REMOVABLE_DISC      = 3'h3;
	localparam logic [PORT_W-1:0] PORT_SPARE               = 3'h4;

	// Bit i stands for slot i+1: fixed ownership per slot
	localparam logic [NUM_SLOTS-1:0] FIXED_SLOT_MASK = 5'h07;
	// Owner of each fixed slot, three bits per slot, slot 1 lowest
	localparam logic [NUM_SLOTS*PORT_W-1:0] FIXED_SLOT_OWNER = {
		3'h0, 3'h0, PORT_CONTROLLER_SELECTOR,
		PORT_PROCESSOR_LINK_UNIT, PORT_CONTROLLER_SELECTOR};
endpackage

// ==== rtl/slot_cycle_if.sv ====
`timescale 1ns/1ps
`default_nettype none
interface slot_cycle_if;
	// Requests, one lane per option module; nets so each end drives its lane
	wire  [slot_arb_pkg::NUM_PORTS-1:0]                      req;
	wire  [slot_arb_pkg::NUM_PORTS-1:0]                      write;
	wire  [slot_arb_pkg::NUM_PORTS*slot_arb_pkg::ADDR_W-1:0] addr;
	wire  [slot_arb_pkg::NUM_PORTS*slot_arb_pkg::WORD_W-1:0] wdata;
	// Answers from the processor
	logic [slot_arb_pkg::NUM_PORTS-1:0]                      grant;
	logic [slot_arb_pkg::SLOT_W-1:0]                         slot;
	logic                                                    rd_valid;
	logic [slot_arb_pkg::PORT_W-1:0]                         rd_port;
	logic [slot_arb_pkg::WORD_W-1:0]                         rdata;

	modport processor (
		input  req,
		input  write,
		input  addr,
		input  wdata,
		output grant,
		output slot,
		output rd_valid,
		output rd_port,
		output rdata
	);

	modport option_module (
		output req,
		output write,
		output addr,
		output wdata,
		input  grant,
		input  slot,
		input  rd_valid,
		input  rd_port,
		input  rdata
	);
endinterface
`default_nettype wire

// ==== rtl/slot_requester.sv ====
`timescale 1ns/1ps
`default_nettype none
module slot_requester #(
	parameter logic [slot_arb_pkg::PORT_W-1:0] PORT =
		slot_arb_pkg::PORT_CONTROLLER_SELECTOR
) (
	// Clock and reset
	input  wire logic                             CLK_IN,
	input  wire logic                             RST_N_IN,
	// Transfer request from the module's mechanisms
	input  wire logic                             XFER_REQ_IN,
	input  wire logic                             XFER_WRITE_IN,
	input  wire logic [slot_arb_pkg::ADDR_W-1:0]  XFER_ADDR_IN,
	input  wire logic [slot_arb_pkg::WORD_W-1:0]  XFER_WDATA_IN,
	output logic                                  XFER_READY_OUT,
	// Completion
	output logic                                  XFER_DONE_OUT,
	output logic [slot_arb_pkg::WORD_W-1:0]       XFER_RDATA_OUT,
	// Processor link
	slot_cycle_if.option_module                   link
);
	localparam int AW = slot_arb_pkg::ADDR_W;
	localparam int WW = slot_arb_pkg::WORD_W;

	typedef enum {IDLE, WAIT_SLOT, WAIT_READ} req_state_t;
	req_state_t state;
	req_state_t next_state;

	logic          is_write;
	logic [AW-1:0] addr;
	logic [WW-1:0] wdata;

	wire granted  = link.grant[PORT];
	wire mine_rd  = link.rd_valid && (link.rd_port == PORT);
	wire accept   = (state == IDLE) && XFER_REQ_IN;

	// One word in flight; mechanisms sharing this port queue upstream
	assign XFER_READY_OUT    = (state == IDLE); // RULE8
	assign link.req[PORT]    = (state == WAIT_SLOT); // RULE5
	assign link.write[PORT]  = is_write;
	assign link.addr[PORT*AW +: AW]  = addr;
	assign link.wdata[PORT*WW +: WW] = wdata;

	always_comb begin
		next_state = state;
		case (state)
			IDLE:      if (XFER_REQ_IN) next_state = WAIT_SLOT;
			WAIT_SLOT: if (granted) next_state = is_write ? IDLE : WAIT_READ;
			WAIT_READ: if (mine_rd) next_state = IDLE;
			default:   next_state = IDLE;
		endcase
	end

	always_ff @(posedge CLK_IN) begin
		if (!RST_N_IN) begin
			state    <= IDLE;
			is_write <= 1'b0;
			addr     <= '0;
			wdata    <= '0;
		end else begin
			state <= next_state;
			if (accept) begin
				is_write <= XFER_WRITE_IN;
				addr     <= XFER_ADDR_IN;
				wdata    <= XFER_WDATA_IN;
			end
		end
	end

	// Write completes with the stolen word time, read when data returns
	always_ff @(posedge CLK_IN) begin
		if (!RST_N_IN) begin
			XFER_DONE_OUT  <= 1'b0;
			XFER_RDATA_OUT <= '0;
		end else begin
			XFER_DONE_OUT <= (state == WAIT_SLOT && granted && is_write) ||
				(state == WAIT_READ && mine_rd);
			if (state == WAIT_READ && mine_rd) begin
				XFER_RDATA_OUT <= link.rdata;
			end
		end
	end
endmodule // slot_requester
`default_nettype wire

// ==== bench/slot_arb_sva.sv ====
`timescale 1ns/1ps
`default_nettype none
module slot_arb_sva (
	// Clock and reset
	input wire logic                               CLK_IN,
	input wire logic                               RST_N_IN,
	// Link signals
	input wire logic [slot_arb_pkg::NUM_PORTS-1:0] req,
	input wire logic [slot_arb_pkg::NUM_PORTS-1:0] write,
	input wire logic [slot_arb_pkg::NUM_PORTS-1:0] grant,
	input wire logic [slot_arb_pkg::SLOT_W-1:0]    slot,
	input wire logic                               rd_valid
);
	default clocking cb @(posedge CLK_IN); endclocking
	default disable iff (!RST_N_IN);

	AST_SLOT_RANGE: assert property (slot >= 3'h1 && slot <= 3'h5)
		else $error("slot number out of range");
	AST_SLOT_STEP: assert property (slot != 3'h5 |=> slot == $past(slot) + 3'h1)
		else $error("slot did not advance by one");
	AST_SLOT_WRAP: assert property (slot == 3'h5 |=> slot == 3'h1)
		else $error("slot did not wrap to one");
	AST_ONE_OWNER: assert property ($onehot0(grant))
		else $error("more than one grant");
	AST_GRANT_REQ: assert property ((grant & ~req) == 5'h00)
		else $error("grant without request");
	AST_CS_SLOTS: assert property ((slot == 3'h1 || slot == 3'h3) |->
		grant[4:1] == 4'h0 && grant[0] == req[0])
		else $error("selector slot misgranted");
	AST_LINK_SLOT: assert property (slot == 3'h2 |->
		grant == {3'h0, req[1], 1'b0})
		else $error("link slot misgranted");
	AST_READ_ANSWER: assert property ((grant != 5'h00 &&
		(grant & write) == 5'h00) |-> ##2 rd_valid)
		else $error("read word missing");
	AST_NO_SPURIOUS_READ: assert property (rd_valid |->
		$past(grant, 2) != 5'h00 && ($past(grant, 2) & $past(write, 2)) == 5'h00)
		else $error("read word without read grant");

	cover property (slot == 3'h3 && grant[0]);
	cover property (rd_valid);
	cover property (grant[4]);
endmodule // slot_arb_sva
`default_nettype wire

// ==== bench/tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic        clk, rst_n, chk_en;
	logic [4:0]  plug_en;
	logic [14:0] plug_own;
	wire logic   steal, mem_we;
	wire logic [14:0] mem_addr;
	wire logic [17:0] mem_wdata, mem_rdata;
	logic [17:0] mem [32];
	logic [17:0] refm [32];
	logic        xreq [5], xwr [5];
	logic [14:0] xad [5];
	logic [17:0] xwd [5];
	wire logic   xrdy [5], xdone [5];
	wire logic [17:0] xrd [5];
	int          errors = 0, n_checks = 0, seed = 32'h35CE, s = 1;
	int          own [1:5] = '{0, 1, 0, 2, 3};
	logic [4:0]  eg;
	logic        stl = 0;

	slot_cycle_if lnk ();
	slot_arbiter slot_arbiter_i (.CLK_IN(clk), .RST_N_IN(rst_n),
		.SLOT_PLUG_EN_IN(plug_en), .SLOT_PLUG_OWNER_IN(plug_own),
		.STEAL_OUT(steal), .MEM_WE_OUT(mem_we), .MEM_ADDR_OUT(mem_addr),
		.MEM_WDATA_OUT(mem_wdata), .MEM_RDATA_IN(mem_rdata), .link(lnk));
	for (genvar i = 0; i < 5; i++) begin : g_mod
		slot_requester #(.PORT(i)) slot_requester_i (.CLK_IN(clk),
			.RST_N_IN(rst_n), .XFER_REQ_IN(xreq[i]), .XFER_WRITE_IN(xwr[i]),
			.XFER_ADDR_IN(xad[i]), .XFER_WDATA_IN(xwd[i]),
			.XFER_READY_OUT(xrdy[i]), .XFER_DONE_OUT(xdone[i]),
			.XFER_RDATA_OUT(xrd[i]), .link(lnk));
	end
	slot_arb_sva slot_arb_sva_i (.CLK_IN(clk), .RST_N_IN(rst_n),
		.req(lnk.req), .write(lnk.write), .grant(lnk.grant),
		.slot(lnk.slot), .rd_valid(lnk.rd_valid));

	always #2.5 clk = ~clk;
	// Combinational read, as the stolen cycle expects
	assign mem_rdata = mem[mem_addr[4:0]];
	always @(posedge clk) if (mem_we) mem[mem_addr[4:0]] <= mem_wdata;

	// Reference slot counter and grant
	always @* eg = (own[s] < 5 && lnk.req[own[s]]) ? 5'h01 << own[s] : 5'h00;
	always @(posedge clk) begin
		stl <= rst_n && eg != 5'h00;
		s <= (!rst_n || s == 5) ? 1 : s + 1;
	end
	always @(negedge clk) if (rst_n && chk_en) begin
		check("slot", 18'(lnk.slot), 18'(s));
		check("grant", 18'(lnk.grant), 18'(eg));
		check("steal", 18'(steal), 18'(stl));
	end

	task automatic check(string nm, logic [17:0] seen, logic [17:0] exp);
		n_checks++;
		if (seen !== exp) begin
			errors++;
			$display("[FAIL] %s exp %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic xfer(int p, bit w, logic [14:0] a, logic [17:0] d);
		int k;
		@(negedge clk);
		xreq[p] = 1; xwr[p] = w; xad[p] = a; xwd[p] = d;
		do @(posedge clk); while (xrdy[p] !== 1'b1);
		@(negedge clk);
		xreq[p] = 0;
		for (k = 0; k < 100 && xdone[p] !== 1'b1; k++) @(negedge clk);
		check("done", 18'(xdone[p]), 18'h00001);
		if (!w) check("rdata", xrd[p], refm[a[4:0]]);
		else refm[a[4:0]] = d;
	endtask

	task automatic run(int q);
		repeat (12) xfer(q, 1'($random(seed)), {10'h000, 3'(q),
			2'($random(seed))}, 18'($random(seed)));
	endtask

	task wrap_up;
		$display("checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	initial begin
		#100000;
		errors++;
		wrap_up;
	end

	initial begin
		clk = 0; rst_n = 0; chk_en = 0; plug_en = 5'h19;
		// Slot 1 plug value must lose to the fixed owner
		plug_own = {3'h3, 3'h2, 3'h0, 3'h0, 3'h4};
		for (int i = 0; i < 5; i++) begin
			xreq[i] = 0; xwr[i] = 0; xad[i] = 0; xwd[i] = 0;
		end
		for (int i = 0; i < 32; i++) begin
			mem[i] = 0; refm[i] = 0;
		end
		repeat (16) @(negedge clk);
		rst_n = 1; chk_en = 1;
		for (int p = 0; p < 4; p++) fork
			automatic int q = p;
			run(q);
		join_none
		wait fork;
		// Spare port owns no slot yet: no steal
		fork xfer(4, 1, 15'h0013, 18'h2AAAA); join_none
		repeat (20) @(negedge clk);
		check("refused", 18'(xrdy[4]), 18'h00000);
		chk_en = 0;
		plug_own[14:12] = 3'h4; own[5] = 4;
		repeat (4) @(negedge clk);
		chk_en = 1;
		wait fork;
		xfer(4, 0, 15'h0013, 18'h00000);
		wrap_up;
	end
endmodule // tb
`default_nettype wire
